// ==== logic/fcac_top.sv ====
// Overview of operation
// - Launching a sector erase abort leaves the command buffer empty flag clear until the abort ends.
// - Starting a new command sequence while an abort is still active sets the access error flag.
// - The access error flag clears only by writing one to it, and no command is processed while it is set.
// - An array write before the clock divider register was ever written sets the access error flag.
// - An array write while the command buffer empty flag is clear sets the access error flag.
// - A second array write before the pending command is launched sets the access error flag.
// - A second command register write before launch sets the access error flag.
// - After an array write, writing the divider or status register sets the error flag.
// - Only codes 05, 20, 25, 40, 41 and 47 are accepted; any other code sets the access error flag.
// - Writing the status register to clear the command buffer empty flag launches the loaded command.
// - After the command code, writing the divider or command register sets the error flag.
// - Entering stop mode during a program or erase aborts it and sets the access error flag.
// - While secured, codes 20, 25, 40 or 47 from the background debug path set the access error flag.
// - Writing zero to the command buffer empty flag to cancel a partial command sets the error flag.
`timescale 1ns/1ns
module fcac_top
	import fcac_pkg::*;
(
	// Clock and reset
	input  wire logic       CLK_SYS,
	input  wire logic       RST_B,
	// Register port
	input  wire logic [2:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	// Array write and write origin
	input  wire logic       ARRAY_WR,
	input  wire logic       DEBUG_SRC,
	input  wire logic       SECURED,
	// Array engine and power
	input  wire logic       STOP_ENTRY,
	input  wire logic       OP_DONE,
	output logic            OP_START,
	output logic            OP_KILL,
	output logic      [7:0] OP_CODE,
	output logic      [7:0] CLK_DIV,
	// Interrupt
	output logic            IRQ
);

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	fcac_seq_e seq_q;
	logic      div_seen_q;
	logic      cbef_q;
	logic      busy_q;
	logic      abort_q;
	logic      aerr_q;
	logic      err_set;
	logic      launch;
	logic      stop_abort;
	logic      code_ok;
	logic      code_locked;
	logic      w_div;
	logic      w_stat;
	logic      w_cmd;

	assign w_div  = WR && (ADDR == FCAC_OFS_DIV);
	assign w_stat = WR && (ADDR == FCAC_OFS_STAT);
	assign w_cmd  = WR && (ADDR == FCAC_OFS_CMD);

	always_comb begin
		case (WDATA)
			FCAC_CMD_BLANK, FCAC_CMD_BYTE, FCAC_CMD_BURST,
			FCAC_CMD_SECT, FCAC_CMD_MASS, FCAC_CMD_ABORT: code_ok = 1'b1;
			default: code_ok = 1'b0;
		endcase
	end

	// Debug access to a secured part may only blank check or mass erase.
	assign code_locked = DEBUG_SRC && SECURED && (WDATA != FCAC_CMD_BLANK) && (WDATA != FCAC_CMD_MASS);
	assign stop_abort  = STOP_ENTRY && busy_q && !abort_q;

	// ----------------------------------------------------------------
	// Protocol violations
	// ----------------------------------------------------------------
	// While the error flag is set every array and command write is ignored and a
	// status write only clears the flag; a divider write still loads the divider.
	always_comb begin
		err_set = stop_abort;
		launch  = 1'b0;
		if (!aerr_q) begin
			if (ARRAY_WR) begin
				if (!div_seen_q) begin
					err_set = 1'b1;
				end else if (!cbef_q) begin
					err_set = 1'b1;
				end else if (seq_q != FCAC_IDLE) begin
					err_set = 1'b1;
				end
			end else if (w_cmd) begin
				case (seq_q)
					FCAC_ADDR: err_set = err_set | !code_ok | code_locked;
					FCAC_CMD:  err_set = 1'b1;
					default:   err_set = err_set | !cbef_q;
				endcase
			end else if (w_stat) begin
				case (seq_q)
					FCAC_ADDR: err_set = 1'b1;
					FCAC_CMD: begin
						if (WDATA[FCAC_STAT_CBEF]) begin
							launch = !stop_abort;
						end else begin
							err_set = 1'b1;
						end
					end
					default: err_set = err_set;
				endcase
			end else if (w_div && (seq_q != FCAC_IDLE)) begin
				err_set = 1'b1;
			end
		end
	end

	fcac_flag u_aerr (
		.CLK_SYS (CLK_SYS),
		.RST_B   (RST_B),
		.set_ev  (err_set),
		.clr_ev  (w_stat && WDATA[FCAC_STAT_AERR]),
		.flag_q  (aerr_q)
	);

	// ----------------------------------------------------------------
	// Command sequence
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			seq_q <= FCAC_IDLE;
		end else if (err_set || launch) begin
			seq_q <= FCAC_IDLE;
		end else if (!aerr_q && ARRAY_WR) begin
			seq_q <= FCAC_ADDR;
		end else if (!aerr_q && w_cmd && (seq_q == FCAC_ADDR)) begin
			seq_q <= FCAC_CMD;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			OP_CODE <= FCAC_RST_BYTE;
		end else if (!aerr_q && w_cmd && (seq_q == FCAC_ADDR) && !err_set) begin
			OP_CODE <= WDATA;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			div_seen_q <= 1'b0;
			CLK_DIV    <= FCAC_RST_BYTE;
		end else if (w_div && !err_set && (seq_q == FCAC_IDLE)) begin
			div_seen_q <= 1'b1;
			CLK_DIV    <= WDATA;
		end
	end

	// ----------------------------------------------------------------
	// Execution state
	// ----------------------------------------------------------------
	// The buffer empty flag drops on launch and returns when the engine
	// reports completion or stop entry kills the run; an abort, which stop
	// entry cannot kill, keeps it clear until completion.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			cbef_q  <= 1'b1;
			busy_q  <= 1'b0;
			abort_q <= 1'b0;
		end else if (launch) begin
			cbef_q  <= 1'b0;
			busy_q  <= 1'b1;
			abort_q <= (OP_CODE == FCAC_CMD_ABORT);
		end else if (OP_DONE || stop_abort) begin
			cbef_q  <= 1'b1;
			busy_q  <= 1'b0;
			abort_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			OP_START <= 1'b0;
			OP_KILL  <= 1'b0;
		end else begin
			OP_START <= launch;
			OP_KILL  <= stop_abort;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	logic [FCAC_IRQ_W-1:0] irq_stat;
	logic [FCAC_IRQ_W-1:0] irq_mask_q;
	logic [FCAC_IRQ_W-1:0] irq_set;
	logic                  w_irqs;

	assign w_irqs                   = WR && (ADDR == FCAC_OFS_IRQS);
	assign irq_set[FCAC_IRQ_AERR]   = err_set && !aerr_q;
	assign irq_set[FCAC_IRQ_DONE]   = busy_q && OP_DONE;

	genvar gi;
	generate
		for (gi = 0; gi < FCAC_IRQ_W; gi++) begin : g_irq
			fcac_flag u_flag (
				.CLK_SYS (CLK_SYS),
				.RST_B   (RST_B),
				.set_ev  (irq_set[gi]),
				.clr_ev  (w_irqs && WDATA[gi]),
				.flag_q  (irq_stat[gi])
			);
		end
	endgenerate

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			irq_mask_q <= FCAC_RST_IRQ;
		end else if (WR && (ADDR == FCAC_OFS_IRQM)) begin
			irq_mask_q <= WDATA[FCAC_IRQ_W-1:0];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |((irq_stat | irq_set) & irq_mask_q);
		end
	end

	// ----------------------------------------------------------------
	// Read back
	// ----------------------------------------------------------------
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = FCAC_RST_BYTE;
		case (ADDR)
			FCAC_OFS_DIV: rd_mux = CLK_DIV;
			FCAC_OFS_STAT: begin
				rd_mux[FCAC_STAT_CBEF]   = cbef_q;
				rd_mux[FCAC_STAT_BUSY]   = busy_q;
				rd_mux[FCAC_STAT_AERR]   = aerr_q;
			end
			FCAC_OFS_CMD:  rd_mux = OP_CODE;
			FCAC_OFS_IRQS: rd_mux[FCAC_IRQ_W-1:0] = irq_stat;
			FCAC_OFS_IRQM: rd_mux[FCAC_IRQ_W-1:0] = irq_mask_q;
			default:       rd_mux = FCAC_RST_BYTE;
		endcase
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			RDATA <= FCAC_RST_BYTE;
		end else if (RD) begin
			RDATA <= rd_mux;
		end else begin
			RDATA <= FCAC_RST_BYTE;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence cmd_loaded_s;
		!aerr_q && (seq_q == FCAC_CMD);
	endsequence

	sequence launch_write_s;
		w_stat && WDATA[FCAC_STAT_CBEF];
	endsequence

	abort_keeps_cbef_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		launch && (OP_CODE == FCAC_CMD_ABORT) |=> !cbef_q && abort_q)
		else $error("Buffer empty flag set after abort launch.");

	abort_holds_cbef_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		abort_q && !OP_DONE |=> !cbef_q)
		else $error("Buffer empty flag set while abort active.");

	abort_new_seq_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		abort_q && ARRAY_WR && !aerr_q |=> aerr_q)
		else $error("New sequence during abort not flagged.");

	err_blocks_start_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		aerr_q |=> !OP_START)
		else $error("Command started while error flag set.");

	no_div_array_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		ARRAY_WR && !div_seen_q && !aerr_q |=> aerr_q && (seq_q == FCAC_IDLE))
		else $error("Array write before divider not flagged.");

	double_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		ARRAY_WR && !aerr_q && (seq_q != FCAC_IDLE) |=> aerr_q)
		else $error("Second array write not flagged.");

	bad_code_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		w_cmd && !aerr_q && (seq_q == FCAC_ADDR) && !code_ok |=> aerr_q && (seq_q == FCAC_IDLE))
		else $error("Illegal command code accepted.");

	launch_start_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		cmd_loaded_s ##0 launch_write_s ##0 !STOP_ENTRY |=> OP_START && !cbef_q ##1 !OP_START)
		else $error("Launch write did not start the command.");

	stop_abort_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		STOP_ENTRY && busy_q && !abort_q |=> OP_KILL && aerr_q && !busy_q)
		else $error("Stop entry did not abort the operation.");

	cancel_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		cmd_loaded_s ##0 (w_stat && !WDATA[FCAC_STAT_CBEF]) |=> aerr_q && !OP_START)
		else $error("Cancel by zero write not flagged.");

	err_sticky_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		aerr_q && !(w_stat && WDATA[FCAC_STAT_AERR]) |=> aerr_q)
		else $error("Error flag cleared without a one write.");

endmodule

// ==== logic/fcac_pkg.sv ====
package fcac_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [2:0] FCAC_OFS_DIV   = 3'h0;
	localparam logic [2:0] FCAC_OFS_STAT  = 3'h1;
	localparam logic [2:0] FCAC_OFS_CMD   = 3'h2;
	localparam logic [2:0] FCAC_OFS_IRQS  = 3'h3;
	localparam logic [2:0] FCAC_OFS_IRQM  = 3'h4;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FCAC_STAT_CBEF   = 7;
	localparam int FCAC_STAT_BUSY   = 6;
	localparam int FCAC_STAT_AERR   = 4;
	localparam int FCAC_IRQ_AERR    = 0;
	localparam int FCAC_IRQ_DONE    = 1;
	localparam int FCAC_IRQ_W       = 2;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] FCAC_CMD_BLANK  = 8'h05;
	localparam logic [7:0] FCAC_CMD_BYTE   = 8'h20;
	localparam logic [7:0] FCAC_CMD_BURST  = 8'h25;
	localparam logic [7:0] FCAC_CMD_SECT   = 8'h40;
	localparam logic [7:0] FCAC_CMD_MASS   = 8'h41;
	localparam logic [7:0] FCAC_CMD_ABORT  = 8'h47;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] FCAC_RST_BYTE   = 8'h00;
	localparam logic [1:0] FCAC_RST_IRQ    = 2'h0;

	typedef enum logic [2:0] {
		FCAC_IDLE = 3'b001,
		FCAC_ADDR = 3'b010,
		FCAC_CMD  = 3'b100
	} fcac_seq_e;

endpackage

`timescale 1ns/1ns
module fcac_flag
	import fcac_pkg::*;
(
	// Clock and reset
	input  wire logic CLK_SYS,
	input  wire logic RST_B,
	// Control
	input  wire logic set_ev,
	input  wire logic clr_ev,
	// State
	output logic      flag_q
);

	// A set in the same cycle as a clear wins, so no event is lost.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			flag_q <= 1'b0;
		end else if (set_ev) begin
			flag_q <= 1'b1;
		end else if (clr_ev) begin
			flag_q <= 1'b0;
		end
	end

endmodule

// ==== testbench/fcac_engine.sv ====
`timescale 1ns/1ns
module fcac_engine #(
	parameter int LAT = 30
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Engine control
	input  wire logic start,
	input  wire logic kill,
	output logic      done
);
	// ----------------------------------------------------------------
	// Array run timer
	// ----------------------------------------------------------------
	// A killed run ends silently, so a stray done would hide a lost abort.
	int cnt_q;
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (!rst_b || kill) begin
			cnt_q <= 0;
		end else if (start) begin
			cnt_q <= LAT;
		end else if (cnt_q > 0) begin
			cnt_q <= cnt_q - 1;
			done <= (cnt_q == 1);
		end
	end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
module tb
	import fcac_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic       clk_sys = 1'b0;
	logic       rst_b, we, re, arr, dbg, sec, stop, op_done;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, op_code, clk_div;
	logic       op_start, op_kill, irq;
	int         n_errors, total_checks;
	logic [7:0] codes [6] = '{FCAC_CMD_BLANK, FCAC_CMD_BYTE, FCAC_CMD_BURST,
		FCAC_CMD_SECT, FCAC_CMD_MASS, FCAC_CMD_ABORT};

	always #4 clk_sys = ~clk_sys;

	fcac_top DUT (.CLK_SYS(clk_sys), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(we), .RD(re),
		.RDATA(rdata), .ARRAY_WR(arr), .DEBUG_SRC(dbg), .SECURED(sec), .STOP_ENTRY(stop),
		.OP_DONE(op_done), .OP_START(op_start), .OP_KILL(op_kill), .OP_CODE(op_code),
		.CLK_DIV(clk_div), .IRQ(irq));
	fcac_engine #(.LAT(30)) eng (.clk(clk_sys), .rst_b(rst_b), .start(op_start), .kill(op_kill),
		.done(op_done));

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bw(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		we <= 1'b0;
	endtask
	task br(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		re <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		re <= 1'b0;
		#1;
		d = rdata;
	endtask
	task ba;
		@(posedge clk_sys);
		arr <= 1'b1;
		@(posedge clk_sys);
		arr <= 1'b0;
	endtask
	// Only the buffer-empty and error bits are compared.
	task st(input logic [7:0] exp);
		logic [7:0] v;
		br(FCAC_OFS_STAT, v);
		chk(v & 8'h90, exp);
	endtask
	task clr;
		bw(FCAC_OFS_STAT, 8'h10);
	endtask
	task go(input logic [7:0] c, input logic e);
		ba;
		bw(FCAC_OFS_CMD, c);
		bw(FCAC_OFS_STAT, 8'h80);
		#1;
		chk(op_start, e);
		if (e)
			chk(op_code, c);
	endtask
	task wt;
		logic [7:0] v;
		repeat (60) begin
			br(FCAC_OFS_STAT, v);
			if (v[7])
				break;
		end
		chk(v[7], 1'b1);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_div;
		chk(clk_div, 8'h00);
		st(8'h80);
		ba;
		st(8'h90);
		bw(FCAC_OFS_IRQM, 8'h01);
		@(posedge clk_sys);
		#1;
		chk(irq, 1'b1);
		bw(FCAC_OFS_DIV, 8'h13);
		#1;
		chk(clk_div, 8'h13);
		go(FCAC_CMD_BYTE, 1'b0);
		st(8'h90);
		clr;
		st(8'h80);
		bw(FCAC_OFS_IRQS, 8'h01);
		@(posedge clk_sys);
		#1;
		chk(irq, 1'b0);
		$display("t_div done");
	endtask
	task t_codes;
		logic [7:0] v;
		for (int i = 0; i < 6; i++) begin
			go(codes[i], 1'b1);
			st(8'h00);
			if (codes[i] == FCAC_CMD_ABORT) begin
				ba;
				st(8'h10);
				clr;
				bw(FCAC_OFS_CMD, FCAC_CMD_BLANK);
				st(8'h10);
				clr;
				@(posedge clk_sys);
				stop <= 1'b1;
				@(posedge clk_sys);
				stop <= 1'b0;
				#1;
				chk(op_kill, 1'b0);
				st(8'h00);
			end
			wt;
		end
		br(FCAC_OFS_IRQS, v);
		chk(v & 8'h02, 8'h02);
		bw(FCAC_OFS_IRQS, 8'h03);
		$display("t_codes done");
	endtask
	task t_bad;
		for (int k = 0; k < 7; k++) begin
			ba;
			case (k)
				0: ba;
				6: bw(FCAC_OFS_STAT, 8'h80);
				2: bw(FCAC_OFS_DIV, 8'h13);
				5: bw(FCAC_OFS_CMD, 8'h21);
				default: bw(FCAC_OFS_CMD, FCAC_CMD_BYTE);
			endcase
			case (k)
				1: bw(FCAC_OFS_CMD, FCAC_CMD_BYTE);
				3: bw(FCAC_OFS_DIV, 8'h13);
				4: bw(FCAC_OFS_STAT, 8'h00);
				default: ;
			endcase
			bw(FCAC_OFS_STAT, 8'h80);
			#1;
			chk(op_start, 1'b0);
			st(8'h90);
			clr;
		end
		$display("t_bad done");
	endtask
	task t_stop;
		go(FCAC_CMD_SECT, 1'b1);
		ba;
		st(8'h10);
		clr;
		@(posedge clk_sys);
		stop <= 1'b1;
		@(posedge clk_sys);
		stop <= 1'b0;
		#1;
		chk(op_kill, 1'b1);
		st(8'h90);
		clr;
		$display("t_stop done");
	endtask
	task t_sec;
		logic e;
		sec <= 1'b1;
		dbg <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			e = codes[i] != FCAC_CMD_BLANK && codes[i] != FCAC_CMD_MASS;
			go(codes[i], !e);
			st(e ? 8'h90 : 8'h00);
			if (e)
				clr;
			else
				wt;
		end
		sec <= 1'b0;
		dbg <= 1'b0;
		$display("t_sec done");
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#100000;
		n_errors++;
		end_sim;
	end

	initial begin
		{rst_b, we, re, arr, dbg, sec, stop} <= '0;
		addr <= 3'h0;
		wdata <= 8'h00;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_div;
		t_codes;
		t_bad;
		t_stop;
		t_sec;
		end_sim;
	end
endmodule
